// ---- src/drive_command_status_logic.v ----
`include "drive_cmd_regs.vh"
module drive_command_status_logic (
	// clock and reset
	input wire clock_in,
	input wire reset_in,
	// object access from the fieldbus side
	input wire write_in,
	input wire [15:0] index_in,
	input wire [15:0] write_data_in,
	output reg [15:0] read_data_out,
	// drive conditions from the motion core
	input wire self_test_done_in,
	input wire fault_event_in,
	input wire fault_cause_present_in,
	input wire fault_reaction_done_in,
	input wire critical_fault_in,
	input wire power_stage_on_in,
	input wire quick_stop_done_in,
	input wire warning_in,
	input wire in_motion_in,
	input wire remote_in,
	input wire limit_in,
	input wire goal_reached_in,
	input wire speed_reached_in,
	input wire standstill_in,
	input wire following_error_in,
	input wire limit_switch_clash_in,
	input wire homing_done_in,
	input wire move_done_in,
	// motion requests, power enable, fault clear and object reports
	output reg start_move_out,
	output reg abort_move_out,
	output reg relative_out,
	output reg start_homing_out,
	output reg abort_homing_out,
	output reg braking_out,
	output reg power_enable_out,
	output reg fault_clear_out,
	output reg [7:0] operating_selection_out,
	output reg [15:0] drive_state_report_out,
	output reg [15:0] drive_command_out
);
	localparam ST_INIT = 3'h0;
	localparam ST_LOCKED = 3'h1;
	localparam ST_ARMABLE = 3'h2;
	localparam ST_ON = 3'h3;
	localparam ST_ENABLED = 3'h4;
	localparam ST_QSTOP = 3'h5;
	localparam ST_REACT = 3'h6;
	localparam ST_FAULT = 3'h7;

	reg [2:0] state;
	reg [2:0] next_state;
	reg [15:0] drive_command;
	reg [7:0] operating_selection;
	reg move_active;
	reg move_pending;
	reg ack_flag;
	reg goal_flag;
	reg halt_stopping;
	reg homing_active;
	reg homing_error;
	wire [1:0] rise;
	wire [1:0] fall;
	wire [15:0] pattern;
	wire pos_mode = (operating_selection == `SEL_POSITION);
	wire vel_mode = (operating_selection == `SEL_VELOCITY);
	wire hom_mode = (operating_selection == `SEL_HOMING);
	wire enabled = (state == ST_ENABLED);
	wire halt_bit = drive_command[`CMD_HALT];
	wire cmd_write = write_in && (index_in == `COMMAND_INDEX);
	wire sel_write = write_in && (index_in == `SELECT_INDEX);
	wire [15:0] status_word;

	// state commands decoded from bits 3..0
	function cmd_disable_voltage;
		input [3:0] c;
		cmd_disable_voltage = ~c[1];
	endfunction
	function cmd_quick_stop;
		input [3:0] c;
		cmd_quick_stop = c[1] & ~c[2];
	endfunction
	function cmd_shutdown;
		input [3:0] c;
		cmd_shutdown = c[2] & c[1] & ~c[0];
	endfunction
	function cmd_switch_on;
		input [3:0] c;
		cmd_switch_on = c[2] & c[1] & c[0];
	endfunction

	edge_detect #(
		.WIDTH(2)
	) u_edges (
		.clock_in(clock_in),
		.reset_in(reset_in),
		.level_in({drive_command[`CMD_FAULT_ACK], drive_command[`CMD_NEW_TARGET]}),
		.rise_out(rise),
		.fall_out(fall)
	);

	state_encoder u_enc (
		.state_in(state),
		.pattern_out(pattern)
	);

	// the master keeps new commands back until the state shows
	// the decode below simply follows the held command word
	always @* begin
		next_state = state;
		case (state)
			ST_INIT: begin
				if (self_test_done_in) begin
					next_state = ST_LOCKED;
				end
			end
			ST_LOCKED: begin
				if (cmd_shutdown(drive_command[3:0])) begin
					next_state = ST_ARMABLE;
				end
			end
			ST_ARMABLE: begin
				if (cmd_disable_voltage(drive_command[3:0]) || cmd_quick_stop(drive_command[3:0])) begin
					next_state = ST_LOCKED;
				end else if (cmd_switch_on(drive_command[3:0])) begin
					next_state = ST_ON;
				end
			end
			ST_ON: begin
				if (cmd_disable_voltage(drive_command[3:0]) || cmd_quick_stop(drive_command[3:0])) begin
					next_state = ST_LOCKED;
				end else if (cmd_shutdown(drive_command[3:0])) begin
					next_state = ST_ARMABLE;
				end else if (cmd_switch_on(drive_command[3:0]) && drive_command[3]) begin
					next_state = ST_ENABLED;
				end
			end
			ST_ENABLED: begin
				if (cmd_disable_voltage(drive_command[3:0])) begin
					next_state = ST_LOCKED;
				end else if (cmd_quick_stop(drive_command[3:0])) begin
					next_state = ST_QSTOP;
				end else if (cmd_shutdown(drive_command[3:0])) begin
					next_state = ST_ARMABLE;
				end else if (cmd_switch_on(drive_command[3:0]) && !drive_command[3]) begin
					next_state = ST_ON;
				end
			end
			ST_QSTOP: begin
				if (cmd_disable_voltage(drive_command[3:0]) || quick_stop_done_in) begin
					next_state = ST_LOCKED;
				end
			end
			ST_REACT: begin
				if (fault_reaction_done_in || critical_fault_in) begin
					next_state = ST_FAULT;
				end
			end
			ST_FAULT: begin
				if (rise[1] && !fault_cause_present_in) begin
					next_state = ST_LOCKED;
				end
			end
			default: next_state = ST_INIT;
		endcase
		if (fault_event_in && state != ST_FAULT && state != ST_INIT) begin
			next_state = critical_fault_in ? ST_FAULT : ST_REACT;
		end
	end

	always @(posedge clock_in) begin
		if (reset_in) begin
			state <= ST_INIT;
			drive_command <= `CMD_RESET;
			operating_selection <= `SEL_POSITION;
		end else begin
			state <= next_state;
			if (cmd_write) begin
				drive_command <= write_data_in;
			end
			if (sel_write && (write_data_in[7:0] == `SEL_POSITION || write_data_in[7:0] == `SEL_VELOCITY
				|| write_data_in[7:0] == `SEL_HOMING)) begin
				operating_selection <= write_data_in[7:0];
			end
		end
	end

	// motion sequencing
	always @(posedge clock_in) begin
		if (reset_in) begin
			move_active <= 1'b0;
			move_pending <= 1'b0;
			ack_flag <= 1'b0;
			goal_flag <= 1'b0;
			halt_stopping <= 1'b0;
			homing_active <= 1'b0;
			homing_error <= 1'b0;
			start_move_out <= 1'b0;
			abort_move_out <= 1'b0;
			relative_out <= 1'b0;
			start_homing_out <= 1'b0;
			abort_homing_out <= 1'b0;
			braking_out <= 1'b0;
			fault_clear_out <= 1'b0;
		end else begin
			start_move_out <= 1'b0;
			abort_move_out <= 1'b0;
			start_homing_out <= 1'b0;
			abort_homing_out <= 1'b0;
			fault_clear_out <= rise[1] && !fault_cause_present_in;
			if (!enabled) begin
				move_active <= 1'b0;
				move_pending <= 1'b0;
				homing_active <= 1'b0;
				halt_stopping <= 1'b0;
			end else if (pos_mode) begin
				if (rise[0]) begin
					ack_flag <= 1'b1;
					goal_flag <= 1'b0;
					relative_out <= drive_command[`CMD_RELATIVE];
					if (!move_active || drive_command[`CMD_IMMEDIATE]) begin
						start_move_out <= 1'b1;
						abort_move_out <= move_active;
						move_active <= 1'b1;
					end else begin
						move_pending <= 1'b1;
					end
				end else if (move_active && move_done_in) begin
					if (move_pending) begin
						start_move_out <= 1'b1;
						move_pending <= 1'b0;
					end else begin
						move_active <= 1'b0;
						goal_flag <= 1'b1;
					end
				end
				if (halt_bit && move_active && !halt_stopping) begin
					abort_move_out <= 1'b1;
					halt_stopping <= 1'b1;
					move_pending <= 1'b0;
				end
				if (halt_stopping && standstill_in) begin
					halt_stopping <= 1'b0;
					move_active <= 1'b0;
					goal_flag <= 1'b1;
				end
			end else if (hom_mode) begin
				if (rise[0] && !halt_bit) begin
					start_homing_out <= 1'b1;
					homing_active <= 1'b1;
					homing_error <= 1'b0;
				end else if (homing_active && (fall[0] || halt_bit)) begin
					abort_homing_out <= 1'b1;
					homing_active <= 1'b0;
					homing_error <= halt_bit;
				end else if (homing_active && homing_done_in) begin
					homing_active <= 1'b0;
				end
				if (limit_switch_clash_in) begin
					homing_error <= 1'b1;
				end
			end
			if (!drive_command[`CMD_NEW_TARGET] && !rise[0]) begin
				ack_flag <= 1'b0;
			end
			braking_out <= enabled && halt_bit && (pos_mode ? halt_stopping : 1'b1);
		end
	end

	assign status_word = {2'b00,
		pos_mode ? (following_error_in && move_active) : (hom_mode & homing_error),
		pos_mode ? ack_flag : (vel_mode ? standstill_in : homing_done_in),
		limit_in,
		pos_mode ? goal_flag : speed_reached_in | goal_reached_in & ~vel_mode,
		remote_in,
		in_motion_in,
		warning_in,
		pattern[6:5],
		power_stage_on_in,
		pattern[3:0]};

	// registered outputs
	always @(posedge clock_in) begin
		if (reset_in) begin
			drive_state_report_out <= 16'h0000;
			drive_command_out <= `CMD_RESET;
			operating_selection_out <= `SEL_POSITION;
			power_enable_out <= 1'b0;
			read_data_out <= 16'h0000;
		end else begin
			drive_state_report_out <= status_word;
			drive_command_out <= drive_command;
			operating_selection_out <= operating_selection;
			power_enable_out <= (state == ST_ON) || enabled || (state == ST_QSTOP) || (state == ST_REACT);
			case (index_in)
				`STATUS_INDEX: read_data_out <= status_word;
				`COMMAND_INDEX: read_data_out <= drive_command;
				`SELECT_INDEX: read_data_out <= {8'h00, operating_selection};
				default: read_data_out <= 16'h0000;
			endcase
		end
	end
endmodule

// ---- src/drive_cmd_regs.vh ----
`ifndef DRIVE_CMD_REGS_VH
`define DRIVE_CMD_REGS_VH
// object indices
`define STATUS_INDEX 16'h6041
`define COMMAND_INDEX 16'h6040
`define SELECT_INDEX 16'h6060
// command word fields
`define CMD_NEW_TARGET 4
`define CMD_IMMEDIATE 5
`define CMD_RELATIVE 6
`define CMD_FAULT_ACK 7
`define CMD_HALT 8
`define CMD_RESET 16'h0006
// status word fields
`define ST_VOLTAGE 4
`define ST_WARNING 7
`define ST_MOVING 8
`define ST_REMOTE 9
`define ST_GOAL 10
`define ST_LIMIT 11
`define ST_MODE12 12
`define ST_MODE13 13
// state patterns, bits 6,5,3,2,1,0 placed in the word
`define SW_INIT_PENDING 16'h0000
`define SW_LOCKED 16'h0040
`define SW_ARMABLE 16'h0021
`define SW_SWITCHED_ON 16'h0023
`define SW_ENABLED 16'h0027
`define SW_QUICK_STOP 16'h0007
`define SW_FAULT_REACT 16'h000F
`define SW_FAULT 16'h0008
// operating selection codes
`define SEL_POSITION 8'h01
`define SEL_VELOCITY 8'h03
`define SEL_HOMING 8'h06
`endif

// ---- src/edge_detect.v ----
// rising and falling detection against the held previous value
module edge_detect #(
	parameter WIDTH = 2
) (
	// clock and reset
	input wire clock_in,
	input wire reset_in,
	// sampled level
	input wire [WIDTH-1:0] level_in,
	// edges
	output wire [WIDTH-1:0] rise_out,
	output wire [WIDTH-1:0] fall_out
);
	reg [WIDTH-1:0] held;
	always @(posedge clock_in) begin
		if (reset_in) begin
			held <= {WIDTH{1'b0}};
		end else begin
			held <= level_in;
		end
	end
	assign rise_out = level_in & ~held;
	assign fall_out = ~level_in & held;
endmodule

// ---- src/state_encoder.v ----
// maps drive state code onto status word bits 6,5,3..0
`include "drive_cmd_regs.vh"
module state_encoder (
	input wire [2:0] state_in,
	output reg [15:0] pattern_out
);
	always @* begin
		case (state_in)
			3'h0: pattern_out = `SW_INIT_PENDING;
			3'h1: pattern_out = `SW_LOCKED;
			3'h2: pattern_out = `SW_ARMABLE;
			3'h3: pattern_out = `SW_SWITCHED_ON;
			3'h4: pattern_out = `SW_ENABLED;
			3'h5: pattern_out = `SW_QUICK_STOP;
			3'h6: pattern_out = `SW_FAULT_REACT;
			3'h7: pattern_out = `SW_FAULT;
			default: pattern_out = `SW_INIT_PENDING;
		endcase
	end
endmodule

// ---- verif/drive_command_status_logic_chk.sv ----
module drive_command_status_logic_chk (
	// clock and reset
	input wire clock_in,
	input wire reset_in,
	// motion core
	input wire power_stage_on_in,
	input wire warning_in,
	input wire in_motion_in,
	input wire remote_in,
	input wire limit_in,
	input wire fault_cause_present_in,
	// reports
	input wire start_move_out,
	input wire braking_out,
	input wire fault_clear_out,
	input wire [7:0] operating_selection_out,
	input wire [15:0] drive_state_report_out,
	input wire [15:0] drive_command_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock_in); endclocking
	default disable iff (reset_in);
	wire [15:0] st = drive_state_report_out;
	wire on = (st & 16'h006F) == 16'h0027;
	a_move_start: assert property (
		$rose(drive_command_out[4]) && drive_command_out[5] && operating_selection_out == 8'h01 && on |->
		start_move_out)
		else $error("new target not started");
	a_clear_cause: assert property (
		fault_clear_out |-> drive_command_out[7] && !$past(fault_cause_present_in))
		else $error("fault cleared without cause gone");
	a_state_code: assert property (
		(st & 16'h004F) inside {16'h0000, 16'h0040, 16'h0001, 16'h0003, 16'h0007, 16'h000F, 16'h0008})
		else $error("illegal state pattern");
	a_power_bit: assert property (
		$stable(power_stage_on_in)[*3] |-> st[4] == power_stage_on_in)
		else $error("voltage bit wrong");
	a_flag_copy: assert property (
		(warning_in && in_motion_in && remote_in && limit_in)[*3] |-> (st & 16'h0B80) == 16'h0B80)
		else $error("flag bits missing");
	a_top_zero: assert property (
		st[15:14] == 2'b00)
		else $error("unused bits set");
	a_select_legal: assert property (
		operating_selection_out inside {8'h01, 8'h03, 8'h06})
		else $error("illegal selection");
	a_halt_brake: assert property (
		(drive_command_out[8] && operating_selection_out == 8'h03 && on)[*3] |-> braking_out)
		else $error("velocity halt not braking");
endmodule
bind drive_command_status_logic drive_command_status_logic_chk drive_command_status_logic_chk_i (
	.clock_in(clock_in), .reset_in(reset_in), .power_stage_on_in(power_stage_on_in),
	.warning_in(warning_in), .in_motion_in(in_motion_in), .remote_in(remote_in), .limit_in(limit_in),
	.fault_cause_present_in(fault_cause_present_in), .start_move_out(start_move_out),
	.braking_out(braking_out), .fault_clear_out(fault_clear_out),
	.operating_selection_out(operating_selection_out), .drive_state_report_out(drive_state_report_out),
	.drive_command_out(drive_command_out)
);

// ---- verif/fieldbus_master.sv ----
module fieldbus_master (
	// clock
	input wire clock_in,
	// object access
	input wire [15:0] read_data_in,
	output logic write_out,
	output logic [15:0] index_out,
	output logic [15:0] data_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		write_out = 1'b0;
		index_out = 16'h6041;
		data_out = 16'h0000;
	end
	task wr(input logic [15:0] idx, input logic [15:0] val);
		@(negedge clock_in);
		write_out = 1'b1;
		index_out = idx;
		data_out = val;
		@(negedge clock_in);
		write_out = 1'b0;
		index_out = 16'h6041;
		data_out = ~val;
		repeat (3) @(negedge clock_in);
	endtask
	task rd(input logic [15:0] idx, output logic [15:0] val);
		@(negedge clock_in);
		index_out = idx;
		repeat (3) @(negedge clock_in);
		val = read_data_in;
	endtask
	// wait for the requested state before the next command
	task poll(input logic [15:0] mask, input logic [15:0] exp, output bit ok);
		logic [15:0] v;
		ok = 0;
		for (int i = 0; i < 20 && !ok; i++) begin
			rd(16'h6041, v);
			ok = (v & mask) === exp;
		end
	endtask
endmodule

// ---- verif/drive_command_status_logic_tb_top.sv ----
module drive_command_status_logic_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_in, reset_in, write_in, self_test_done_in, fault_event_in, fault_cause_present_in;
	logic fault_reaction_done_in, power_stage_on_in, quick_stop_done_in, warning_in, in_motion_in;
	logic remote_in, limit_in, goal_reached_in, speed_reached_in, standstill_in, following_error_in;
	logic homing_done_in, start_move_out, abort_move_out, relative_out, start_homing_out, abort_homing_out;
	logic braking_out, power_enable_out, fault_clear_out, critical_fault_in, limit_switch_clash_in, move_done_in;
	logic [7:0] operating_selection_out;
	logic [15:0] index_in, write_data_in, read_data_out, drive_state_report_out, drive_command_out, v;
	logic [15:0] n [5] = '{default: 16'h0000};
	int bad_count = 0;
	int cmp_count = 0;
	bit ok;
	wire [4:0] p = {fault_clear_out, abort_homing_out, start_homing_out, abort_move_out, start_move_out};
	initial begin
		clock_in = 0;
		forever #5 clock_in = ~clock_in;
	end
	always @(negedge clock_in) power_stage_on_in <= power_enable_out;
	always @(posedge clock_in) if (!reset_in) for (int i = 0; i < 5; i++) n[i] <= n[i] + p[i];
	drive_command_status_logic drive_command_status_logic_i (.clock_in, .reset_in, .write_in, .index_in,
		.write_data_in, .read_data_out, .self_test_done_in, .fault_event_in, .fault_cause_present_in,
		.fault_reaction_done_in, .critical_fault_in, .power_stage_on_in, .quick_stop_done_in, .warning_in,
		.in_motion_in, .remote_in, .limit_in, .goal_reached_in, .speed_reached_in, .standstill_in,
		.following_error_in, .limit_switch_clash_in, .homing_done_in, .move_done_in,
		.start_move_out, .abort_move_out, .relative_out, .start_homing_out, .abort_homing_out, .braking_out,
		.power_enable_out, .fault_clear_out, .operating_selection_out, .drive_state_report_out,
		.drive_command_out);
	fieldbus_master fieldbus_master_i (.clock_in, .read_data_in(read_data_out), .write_out(write_in),
		.index_out(index_in), .data_out(write_data_in));
	task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task state_is(input logic [15:0] mask, input logic [15:0] exp);
		fieldbus_master_i.poll(mask, exp, ok);
		check("state", ok, 16'h0001);
		if (!ok) tally_and_finish();
	endtask
	task rd_is(input string name, input logic [15:0] idx, input logic [15:0] mask, input logic [15:0] exp);
		fieldbus_master_i.rd(idx, v);
		check(name, v & mask, exp);
	endtask
	task cmd(input logic [15:0] val);
		fieldbus_master_i.wr(16'h6040, val);
	endtask
	initial begin
		reset_in = 1;
		{self_test_done_in, fault_event_in, fault_cause_present_in, fault_reaction_done_in} = 4'h0;
		{quick_stop_done_in, homing_done_in, critical_fault_in, limit_switch_clash_in, move_done_in} = 5'h00;
		{following_error_in, standstill_in, speed_reached_in, goal_reached_in} = 4'h0;
		{limit_in, remote_in, in_motion_in, warning_in} = 4'h0;
		repeat (4) @(posedge clock_in);
		@(negedge clock_in);
		reset_in = 0;
		rd_is("status", 16'h6041, 16'hFFFF, 16'h0000);
		rd_is("selection", 16'h6060, 16'h00FF, 16'h0001);
		cmd(16'h0000);
		self_test_done_in = 1;
		state_is(16'h004F, 16'h0040);
		cmd(16'h0006);
		state_is(16'h006F, 16'h0021);
		cmd(16'h0007);
		state_is(16'h006F, 16'h0023);
		cmd(16'h000F);
		state_is(16'h006F, 16'h0027);
		check("report", drive_state_report_out & 16'h006F, 16'h0027);
		rd_is("command", 16'h6040, 16'hFFFF, 16'h000F);
		rd_is("voltage", 16'h6041, 16'h0010, 16'h0010);
		check("power enable", power_enable_out, 16'h0001);
		{homing_done_in, following_error_in, standstill_in, speed_reached_in, goal_reached_in} = 5'h1F;
		{limit_in, remote_in, in_motion_in, warning_in} = 4'hF;
		rd_is("flags", 16'h6041, 16'hFF80, 16'h0B80);
		{homing_done_in, following_error_in, standstill_in, speed_reached_in, goal_reached_in} = 5'h00;
		{limit_in, remote_in, warning_in} = 3'h0;
		in_motion_in = 0;
		cmd(16'h001F);
		check("moves", n[0], 16'h0001);
		rd_is("ack", 16'h6041, 16'h1000, 16'h1000);
		cmd(16'h000F);
		rd_is("ack", 16'h6041, 16'h1000, 16'h0000);
		in_motion_in = 1;
		cmd(16'h007F);
		check("moves", n[0], 16'h0002);
		check("aborts", n[1], 16'h0001);
		check("relative", relative_out, 16'h0001);
		following_error_in = 1;
		rd_is("tracking", 16'h6041, 16'h2000, 16'h2000);
		following_error_in = 0;
		cmd(16'h000F);
		cmd(16'h001F);
		check("queued", n[0], 16'h0002);
		move_done_in = 1;
		@(negedge clock_in);
		move_done_in = 0;
		repeat (2) @(negedge clock_in);
		check("queued", n[0], 16'h0003);
		cmd(16'h010F);
		standstill_in = 1;
		rd_is("goal", 16'h6041, 16'h0400, 16'h0400);
		standstill_in = 0;
		cmd(16'h000F);
		check("aborts", n[1], 16'h0002);
		in_motion_in = 0;
		fieldbus_master_i.wr(16'h6060, 16'h0003);
		cmd(16'h010F);
		check("braking", braking_out, 16'h0001);
		cmd(16'h000F);
		check("braking", braking_out, 16'h0000);
		{standstill_in, speed_reached_in} = 2'b11;
		rd_is("velocity flags", 16'h6041, 16'h3400, 16'h1400);
		{standstill_in, speed_reached_in} = 2'b00;
		fieldbus_master_i.wr(16'h6060, 16'h0007);
		rd_is("selection", 16'h6060, 16'h00FF, 16'h0003);
		fieldbus_master_i.wr(16'h6060, 16'h0006);
		cmd(16'h001F);
		check("homing", n[2], 16'h0001);
		cmd(16'h000F);
		check("homing aborts", n[3], 16'h0001);
		cmd(16'h001F);
		cmd(16'h011F);
		cmd(16'h001F);
		check("homing aborts", n[3], 16'h0002);
		rd_is("homing error", 16'h6041, 16'h2000, 16'h2000);
		homing_done_in = 1;
		rd_is("homing done", 16'h6041, 16'h1000, 16'h1000);
		homing_done_in = 0;
		cmd(16'h000F);
		cmd(16'h001F);
		rd_is("error cleared", 16'h6041, 16'h2000, 16'h0000);
		limit_switch_clash_in = 1;
		rd_is("clash", 16'h6041, 16'h2000, 16'h2000);
		limit_switch_clash_in = 0;
		cmd(16'h000B);
		state_is(16'h006F, 16'h0007);
		quick_stop_done_in = 1;
		state_is(16'h004F, 16'h0040);
		quick_stop_done_in = 0;
		fault_cause_present_in = 1;
		fault_event_in = 1;
		state_is(16'h004F, 16'h000F);
		fault_event_in = 0;
		fault_reaction_done_in = 1;
		state_is(16'h004F, 16'h0008);
		cmd(16'h0080);
		check("clears", n[4], 16'h0000);
		cmd(16'h0000);
		fault_cause_present_in = 0;
		cmd(16'h0080);
		check("clears", n[4], 16'h0001);
		state_is(16'h004F, 16'h0040);
		{fault_reaction_done_in, critical_fault_in, fault_event_in} = 3'b011;
		state_is(16'h004F, 16'h0008);
		tally_and_finish();
	end
endmodule
